//--- core/pmcfg_registers.sv
// Contract
// [RULE1] Identity bit 1 enables write protection
// [RULE2] Identity bits 7:2 report module code
// [RULE3] Vout gain defaults 0x2000, range 0x1999-0x2666
// [RULE4] Vout offset exponent fixed at -12
// [RULE5] Vin gain defaults 0x2000, range limited
// [RULE6] Vin offset exponent fixed at -3
// [RULE7] Iout gain limited to 0x1999-0x2666
// [RULE8] Iout offset exponent fixed at -4
// [RULE9] Protect locks calibration and serial writes
// [RULE10] Firmware revision read-only four BCD digits
// [RULE11] Alert bit selects alert-response-address only
// [RULE12] Bits 3:0 map the two control pins
// [RULE13] Bit 1 ANDs primary and secondary enable
// [RULE14] Bit 0 sets secondary input polarity
// [RULE15] Bit 0 sets power-good pin sense
// [RULE16] Twelve-byte date/location/serial block read/write
// [RULE17] Rejected writes keep value; reserved bits zero
`timescale 1ns/1ps
`default_nettype none
module pmcfg_registers
    import pmcfg_pkg::*;
#(
    // Arbitrary designation code, leading 1 marks an isolated unit
    parameter logic [5:0]  MODULE_NAME = 6'h25,
    // Arbitrary revision, BCD major.minor.build
    parameter logic [15:0] FW_REVISION = 16'h1000,
    parameter int          BLOCK_BYTES = SERIAL_BYTES
) (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [3:0]  i_block_index,
    input  wire logic [15:0] i_wr_data,
    output logic             o_rsp_valid,
    output logic             o_rsp_error,
    output logic [15:0]      o_rsp_data,
    input  wire logic        i_primary_on,
    input  wire logic        i_pin_one,
    input  wire logic        i_pin_two,
    input  wire logic        i_smbalert,
    input  wire logic        i_power_good,
    output logic             o_output_enable,
    output logic             o_trim_select,
    output logic             o_pin_two_out,
    output logic             o_pin_two_oe,
    output logic             o_ara_only,
    output logic             o_write_protect
);
    // Only the twelve-byte block and isolated designations are served
    if (BLOCK_BYTES != SERIAL_BYTES
            || MODULE_NAME[5] != 1'b1) begin : g_param_check
        $error("pmcfg_registers: unsupported parameter value");
    end

    logic        protect_reg;
    logic [15:0] vout_gain_reg, vout_off_reg, vin_gain_reg, vin_off_reg;
    logic [15:0] iout_gain_reg, iout_off_reg;
    logic [4:0]  pin_func_reg;
    logic [1:0]  onoff_reg;
    logic        pg_pol_reg;
    logic [7:0]  serial_mem [BLOCK_BYTES];

    logic [3:0]  sync_a_reg, sync_b_reg;
    logic        rsp_valid_reg, rsp_error_reg;
    logic [15:0] rsp_data_reg;
    logic        enable_reg, trim_reg, pg_out_reg, pg_oe_reg;
    logic        ara_reg;

    function automatic logic gain_ok(input logic [15:0] v);
        return (v >= GAIN_MIN) && (v <= GAIN_MAX);
    endfunction : gain_ok

    function automatic logic exp_ok(input logic [15:0] v,
                                    input logic [4:0]  e);
        return v[15:EXP_LSB] == e;
    endfunction : exp_ok

    // Command decode
    wire wr = i_cmd_valid && i_cmd_write;
    wire rd = i_cmd_valid && !i_cmd_write;
    wire hit_id    = i_cmd_code == CMD_IDENTITY;
    wire hit_vg    = i_cmd_code == CMD_VOUT_GAIN;
    wire hit_vo    = i_cmd_code == CMD_VOUT_OFFSET;
    wire hit_ig    = i_cmd_code == CMD_VIN_GAIN;
    wire hit_io    = i_cmd_code == CMD_VIN_OFFSET;
    wire hit_cg    = i_cmd_code == CMD_IOUT_GAIN;
    wire hit_co    = i_cmd_code == CMD_IOUT_OFFSET;
    wire hit_fw    = i_cmd_code == CMD_FW_REV;
    wire hit_pf    = i_cmd_code == CMD_PIN_FUNC;
    wire hit_ol    = i_cmd_code == CMD_ONOFF_LOGIC;
    wire hit_pg    = i_cmd_code == CMD_PG_POLARITY;
    wire hit_sn    = i_cmd_code == CMD_DATE_SERIAL;
    wire idx_ok    = 32'(i_block_index) < BLOCK_BYTES;
    wire hit_any   = hit_id | hit_vg | hit_vo | hit_ig | hit_io | hit_cg
                   | hit_co | hit_fw | hit_pf | hit_ol | hit_pg
                   | (hit_sn && idx_ok);
    wire locked    = protect_reg;                                // [RULE1]
    // Codes other than the three mappings are refused
    wire map_ok    = i_wr_data[3:0] == MAP_ONOFF_PG
                   || i_wr_data[3:0] == MAP_TRIM_PG
                   || i_wr_data[3:0] == MAP_TRIM_ONOFF;           // [RULE12]

    // Write acceptance, all others leave storage untouched
    wire we_id = wr && hit_id;
    wire we_vg = wr && hit_vg && !locked
               && gain_ok(i_wr_data);                            // [RULE3]
    wire we_vo = wr && hit_vo && !locked
               && exp_ok(i_wr_data, EXP_VOUT);                   // [RULE4]
    wire we_ig = wr && hit_ig && !locked
               && gain_ok(i_wr_data);                            // [RULE5]
    wire we_io = wr && hit_io && !locked
               && exp_ok(i_wr_data, EXP_VIN);                    // [RULE6]
    wire we_cg = wr && hit_cg && !locked
               && gain_ok(i_wr_data);                            // [RULE7]
    wire we_co = wr && hit_co && !locked
               && exp_ok(i_wr_data, EXP_IOUT);                   // [RULE8]
    wire we_pf = wr && hit_pf && map_ok;
    wire we_ol = wr && hit_ol;
    wire we_pg = wr && hit_pg;
    wire we_sn = wr && hit_sn && idx_ok                          // [RULE16]
               && !locked;                                       // [RULE9]
    wire wr_taken = we_id | we_vg | we_vo | we_ig | we_io | we_cg | we_co
                  | we_pf | we_ol | we_pg | we_sn;               // [RULE17]

    // Read data mux, reserved bits zero
    wire [15:0] id_word = {8'h00, MODULE_NAME,                   // [RULE2]
                           protect_reg, 1'b0};                   // [RULE17]
    wire [15:0] rd_word =
          hit_id ? id_word
        : hit_vg ? vout_gain_reg
        : hit_vo ? vout_off_reg
        : hit_ig ? vin_gain_reg
        : hit_io ? vin_off_reg
        : hit_cg ? iout_gain_reg
        : hit_co ? iout_off_reg
        : hit_fw ? FW_REVISION                                   // [RULE10]
        : hit_pf ? {11'h000, pin_func_reg}
        : hit_ol ? {14'h0000, onoff_reg}
        : hit_pg ? {15'h0000, pg_pol_reg}
        : (hit_sn && idx_ok) ? {8'h00, serial_mem[i_block_index]}
        : 16'h0000;
    // Reads fail on unknown codes, writes on any refusal
    wire rsp_err = rd ? !hit_any : !wr_taken;                    // [RULE10]

    // Pin function evaluation on synchronised pins
    wire [3:0] pin_map   = pin_func_reg[3:0];
    // Secondary input sits on pin one for map 0000, else pin two
    wire       sec_raw   = (pin_map == MAP_ONOFF_PG) ? sync_b_reg[1]
                         : sync_b_reg[2];
    wire       sec_has   = pin_map != MAP_TRIM_PG;
    wire       sec_on    = onoff_reg[ONOFF_POL_BIT] ? sec_raw
                         : !sec_raw;                             // [RULE14]
    wire       en_next   = sync_b_reg[0]
                         && (!onoff_reg[ONOFF_MODE_BIT]
                             || (sec_has && sec_on));            // [RULE13]
    wire       pg_drive  = pin_map != MAP_TRIM_ONOFF;            // [RULE12]
    wire       pg_level  = pg_pol_reg ? i_power_good
                         : !i_power_good;                        // [RULE15]
    wire       trim_next = pin_map != MAP_ONOFF_PG;              // [RULE12]
    wire       ara_next  = pin_func_reg[ARA_BIT] && sync_b_reg[3]; // [RULE11]

    // Two-stage synchroniser: primary, pin one, pin two, alert
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sync_a_reg <= 4'h0;
            sync_b_reg <= 4'h0;
        end else begin
            sync_a_reg <= {i_smbalert, i_pin_two, i_pin_one, i_primary_on};
            sync_b_reg <= sync_a_reg;
        end
    end

    // Protect bit stays writable while set, else it could never clear
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            protect_reg <= PROTECT_RESET;
        end else if (we_id) begin
            protect_reg <= i_wr_data[PROTECT_BIT];               // [RULE1]
        end
    end

    // Calibration words, written only when accepted
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            vout_gain_reg <= GAIN_RESET;
        end else if (we_vg) begin
            vout_gain_reg <= i_wr_data;                          // [RULE3]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            vout_off_reg <= {EXP_VOUT, 11'h000};
        end else if (we_vo) begin
            vout_off_reg <= i_wr_data;                           // [RULE4]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            vin_gain_reg <= GAIN_RESET;
        end else if (we_ig) begin
            vin_gain_reg <= i_wr_data;                           // [RULE5]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            vin_off_reg <= {EXP_VIN, 11'h000};
        end else if (we_io) begin
            vin_off_reg <= i_wr_data;                            // [RULE6]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            iout_gain_reg <= GAIN_RESET;
        end else if (we_cg) begin
            iout_gain_reg <= i_wr_data;                          // [RULE7]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            iout_off_reg <= {EXP_IOUT, 11'h000};
        end else if (we_co) begin
            iout_off_reg <= i_wr_data;                           // [RULE8]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            pin_func_reg <= PIN_FUNC_RESET;
        end else if (we_pf) begin
            pin_func_reg <= i_wr_data[4:0];                      // [RULE11]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            onoff_reg <= ONOFF_RESET;
        end else if (we_ol) begin
            onoff_reg <= i_wr_data[1:0];                         // [RULE13]
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            pg_pol_reg <= PG_POL_RESET;
        end else if (we_pg) begin
            pg_pol_reg <= i_wr_data[PG_POL_BIT];                 // [RULE15]
        end
    end

    // Serial block holds no reset: contents are factory data
    always_ff @(posedge i_clock) begin
        if (we_sn) serial_mem[i_block_index] <= i_wr_data[7:0];  // [RULE16]
    end

    // Response stands one cycle after each command
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            rsp_valid_reg <= 1'b0;
            rsp_error_reg <= 1'b0;
            rsp_data_reg  <= 16'h0000;
        end else begin
            rsp_valid_reg <= i_cmd_valid;
            rsp_error_reg <= i_cmd_valid && rsp_err;
            rsp_data_reg  <= rd ? rd_word : 16'h0000;
        end
    end

    // Pin outputs registered so every port comes from a flop
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            enable_reg <= 1'b0;
            trim_reg   <= 1'b0;
            pg_out_reg <= 1'b0;
            pg_oe_reg  <= 1'b0;
            ara_reg    <= 1'b0;
        end else begin
            enable_reg <= en_next;
            trim_reg   <= trim_next;
            pg_out_reg <= pg_level;
            pg_oe_reg  <= pg_drive;
            ara_reg    <= ara_next;
        end
    end

    assign o_rsp_valid     = rsp_valid_reg;
    assign o_rsp_error     = rsp_error_reg;
    assign o_rsp_data      = rsp_data_reg;
    assign o_output_enable = enable_reg;
    assign o_trim_select   = trim_reg;
    assign o_pin_two_out   = pg_out_reg;
    assign o_pin_two_oe    = pg_oe_reg;
    assign o_ara_only      = ara_reg;
    assign o_write_protect = protect_reg;
endmodule : pmcfg_registers
`default_nettype wire

//--- core/pmcfg_pkg.sv
package pmcfg_pkg;
    // Command codes
    localparam logic [7:0] CMD_IDENTITY     = 8'hD0;
    localparam logic [7:0] CMD_VOUT_GAIN    = 8'hD1;
    localparam logic [7:0] CMD_VOUT_OFFSET  = 8'hD2;
    localparam logic [7:0] CMD_VIN_GAIN     = 8'hD3;
    localparam logic [7:0] CMD_VIN_OFFSET   = 8'hD4;
    localparam logic [7:0] CMD_IOUT_GAIN    = 8'hD6;
    localparam logic [7:0] CMD_IOUT_OFFSET  = 8'hD7;
    localparam logic [7:0] CMD_FW_REV       = 8'hDB;
    localparam logic [7:0] CMD_PIN_FUNC     = 8'hE0;
    localparam logic [7:0] CMD_ONOFF_LOGIC  = 8'hE1;
    localparam logic [7:0] CMD_PG_POLARITY  = 8'hE2;
    localparam logic [7:0] CMD_DATE_SERIAL  = 8'hF0;

    // Field positions
    localparam int PROTECT_BIT    = 1;
    localparam int NAME_LSB       = 2;
    localparam int ARA_BIT        = 4;
    localparam int ONOFF_MODE_BIT = 1;
    localparam int ONOFF_POL_BIT  = 0;
    localparam int PG_POL_BIT     = 0;
    localparam int EXP_LSB        = 11;

    // Reset values, gain limits and block size
    localparam logic        PROTECT_RESET = 1'b1;
    localparam logic [15:0] GAIN_RESET    = 16'h2000;
    localparam logic [15:0] GAIN_MIN      = 16'h1999;
    localparam logic [15:0] GAIN_MAX      = 16'h2666;
    localparam logic [4:0]  EXP_VOUT      = 5'h14;
    localparam logic [4:0]  EXP_VIN       = 5'h1D;
    localparam logic [4:0]  EXP_IOUT      = 5'h1C;
    localparam logic [4:0]  PIN_FUNC_RESET = 5'h00;
    localparam logic [1:0]  ONOFF_RESET   = 2'h0;
    localparam logic        PG_POL_RESET  = 1'b0;
    localparam int          SERIAL_BYTES  = 12;

    // Pin mappings
    localparam logic [3:0] MAP_ONOFF_PG   = 4'h0;
    localparam logic [3:0] MAP_TRIM_PG    = 4'h1;
    localparam logic [3:0] MAP_TRIM_ONOFF = 4'h2;
endpackage : pmcfg_pkg

//--- verification/pmcfg_reg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pmcfg_reg_properties
    import pmcfg_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_resetn,
    input wire logic        i_cmd_valid,
    input wire logic        i_cmd_write,
    input wire logic [7:0]  i_cmd_code,
    input wire logic [15:0] i_wr_data,
    input wire logic        o_rsp_valid,
    input wire logic        o_rsp_error,
    input wire logic        o_trim_select,
    input wire logic        o_pin_two_oe,
    input wire logic        o_write_protect
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    wire logic       wr = i_cmd_valid && i_cmd_write;
    wire logic       protect_in = i_wr_data[PROTECT_BIT];
    wire logic [4:0] ex = i_wr_data[15:11];
    wire logic gain_bad = i_wr_data < GAIN_MIN || i_wr_data > GAIN_MAX;
    wire logic gain_cmd = i_cmd_code inside {CMD_VOUT_GAIN, CMD_VIN_GAIN,
        CMD_IOUT_GAIN};
    wire logic exp_bad = (i_cmd_code == CMD_VOUT_OFFSET && ex != EXP_VOUT)
        || (i_cmd_code == CMD_VIN_OFFSET && ex != EXP_VIN)
        || (i_cmd_code == CMD_IOUT_OFFSET && ex != EXP_IOUT);
    wire logic locked = o_write_protect && (gain_cmd || i_cmd_code inside
        {CMD_VOUT_OFFSET, CMD_VIN_OFFSET, CMD_IOUT_OFFSET, CMD_DATE_SERIAL});
    sequence wr_s(c);
        wr && i_cmd_code == c;
    endsequence
    sequence trim_map_s;
        wr_s(CMD_PIN_FUNC) ##0 i_wr_data[3:0] == MAP_TRIM_ONOFF
        ##1 !o_rsp_error;
    endsequence
    rsp_strobe_a: assert property (
        o_rsp_valid == $past(i_cmd_valid))
        else $error("response strobe out of step");
    locked_write_a: assert property (wr && locked |=> o_rsp_error)
        else $error("locked write accepted");
    gain_range_a: assert property (
        wr && gain_cmd && gain_bad |=> o_rsp_error)
        else $error("gain outside range accepted");
    offset_exp_a: assert property (
        wr && exp_bad |=> o_rsp_error)
        else $error("offset with wrong exponent accepted");
    fw_readonly_a: assert property (
        wr_s(CMD_FW_REV) |=> o_rsp_error)
        else $error("revision write accepted");
    protect_update_a: assert property (wr_s(CMD_IDENTITY) |=>
        !o_rsp_error && o_write_protect == $past(protect_in))
        else $error("protect bit not taken");
    pin_map_a: assert property (wr_s(CMD_PIN_FUNC) ##0
        i_wr_data[3:0] > MAP_TRIM_ONOFF |=> o_rsp_error)
        else $error("bad pin map accepted");
    trim_map_a: assert property (trim_map_s |-> ##[0:2]
        (o_trim_select && !o_pin_two_oe))
        else $error("trim mapping not applied");
endmodule : pmcfg_reg_properties
bind pmcfg_registers pmcfg_reg_properties u_props (.*);
`default_nettype wire

//--- verification/pmcfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmcfg_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_rsp_valid,
    input  wire logic        i_rsp_error,
    input  wire logic [15:0] i_rsp_data,
    output logic             o_cmd_valid = 1'b0,
    output logic             o_cmd_write = 1'b0,
    output logic [7:0]       o_cmd_code = 8'h00,
    output logic [3:0]       o_block_index = 4'h0,
    output logic [15:0]      o_wr_data = 16'h0000
);
    // One command a call, answer taken in the following cycle
    task automatic xfer(input logic w, input logic [7:0] c,
        input logic [3:0] x, input logic [15:0] d,
        output logic [15:0] rd, output logic e);
        @(negedge i_clock);
        {o_cmd_valid, o_cmd_write, o_cmd_code} = {1'b1, w, c};
        {o_block_index, o_wr_data} = {x, d};
        @(negedge i_clock);
        // Released lines carry the inverse, not the old value
        {o_cmd_valid, o_cmd_write, o_cmd_code} = {1'b0, ~w, ~c};
        {o_block_index, o_wr_data} = {~x, ~d};
        e = (i_rsp_valid === 1'b1) ? i_rsp_error : 1'bx;
        rd = i_rsp_data;
    endtask : xfer
endmodule : pmcfg_host_model
`default_nettype wire

//--- verification/pmcfg_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmcfg_registers_tb;
    import pmcfg_pkg::*;
    // Arbitrary designation with leading 1, arbitrary revision
    localparam logic [5:0]  NAME = 6'h2A;
    localparam logic [15:0] FW = 16'h3107;
    logic i_clock = 1'b0, i_resetn = 1'b0, i_primary_on = 1'b0;
    logic i_pin_one = 1'b0, i_smbalert = 1'b0, i_power_good = 1'b0;
    logic pin_two_drv = 1'b0, err, i_cmd_valid, i_cmd_write;
    logic o_rsp_valid, o_rsp_error, o_output_enable, o_trim_select;
    logic o_pin_two_out, o_pin_two_oe, o_ara_only, o_write_protect;
    logic [7:0]  i_cmd_code;
    logic [3:0]  i_block_index;
    logic [15:0] i_wr_data, o_rsp_data, rdat;
    int          n_fail = 0, comparisons = 0;
    wire logic   i_pin_two = o_pin_two_oe ? o_pin_two_out : pin_two_drv;
    logic [7:0]  rc [11] = '{CMD_IDENTITY, CMD_VOUT_GAIN, CMD_VOUT_OFFSET,
        CMD_VIN_GAIN, CMD_VIN_OFFSET, CMD_IOUT_GAIN, CMD_IOUT_OFFSET,
        CMD_FW_REV, CMD_PIN_FUNC, CMD_ONOFF_LOGIC, CMD_PG_POLARITY};
    logic [15:0] rv [11] = '{{8'h00, NAME, 2'h2}, GAIN_RESET,
        {EXP_VOUT, 11'h000}, GAIN_RESET, {EXP_VIN, 11'h000}, GAIN_RESET,
        {EXP_IOUT, 11'h000}, FW, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] gv [4] = '{GAIN_MIN, GAIN_MAX + 16'h0001, GAIN_MAX,
        GAIN_MIN - 16'h0001};
    always #5 i_clock = ~i_clock;
    pmcfg_registers #(.MODULE_NAME(NAME), .FW_REVISION(FW)) dut (.*);
    pmcfg_host_model host (.i_clock(i_clock), .i_rsp_valid(o_rsp_valid),
        .i_rsp_error(o_rsp_error), .i_rsp_data(o_rsp_data),
        .o_cmd_valid(i_cmd_valid), .o_cmd_write(i_cmd_write),
        .o_cmd_code(i_cmd_code), .o_block_index(i_block_index),
        .o_wr_data(i_wr_data));
    task automatic check(input string s, input logic [16:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, exp, got);
        end
    endtask : check
    task automatic op(input string s, input logic w, input logic [7:0] c,
        input logic [3:0] x, input logic [15:0] d, input logic e,
        input logic [15:0] v);
        host.xfer(w, c, x, d, rdat, err);
        check(s, {err, (e && !w) ? 16'h0000 : rdat}, {e, v});
    endtask : op
    // Pin levels pass two sync flops and an output flop
    task automatic pin_chk(input string s, input logic [4:0] exp);
        repeat (6) @(negedge i_clock);
        check(s, {o_output_enable, o_trim_select, o_pin_two_oe,
            o_pin_two_oe & o_pin_two_out, o_ara_only}, exp);
    endtask : pin_chk
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(negedge i_clock);
        i_resetn = 1'b1;
        for (int k = 0; k < 11; k++)
            op("reset", 0, rc[k], 0, 0, 0, rv[k]);
        for (int k = 1; k < 7; k++) begin
            op("locked", 1, rc[k], 0, rv[k] | 16'h0100, 1, 0);
            op("kept", 0, rc[k], 0, 0, 0, rv[k]);
        end
        op("sn lock", 1, CMD_DATE_SERIAL, 0, 16'h0055, 1, 0);
        op("fw wr", 1, CMD_FW_REV, 0, 16'h1234, 1, 0);
        op("fw rd", 0, CMD_FW_REV, 0, 0, 0, FW);
        op("unknown", 0, 8'hD5, 0, 0, 1, 0);
        $display("test lockout done");
        op("unlock", 1, CMD_IDENTITY, 0, 16'hFF01, 0, 0);
        check("protect", o_write_protect, 1'b0);
        op("ident", 0, CMD_IDENTITY, 0, 0, 0, {8'h00, NAME, 2'h0});
        for (int k = 1; k < 6; k += 2) begin
            foreach (gv[j])
                op("gain", 1, rc[k], 0, gv[j], j[0], 0);
            op("gain rd", 0, rc[k], 0, 0, 0, GAIN_MAX);
        end
        for (int k = 2; k < 7; k += 2) begin
            op("off", 1, rc[k], 0, rv[k] | 16'h0123, 0, 0);
            op("exp", 1, rc[k], 0, rv[k] ^ 16'h0FFF, 1, 0);
            op("off rd", 0, rc[k], 0, 0, 0, rv[k] | 16'h0123);
        end
        $display("test calibration done");
        for (int k = 0; k < SERIAL_BYTES; k++)
            op("sn", 1, CMD_DATE_SERIAL, k[3:0], 16'h00A5 ^ 16'(k),
                0, 0);
        for (int k = 0; k < SERIAL_BYTES; k++)
            op("sn rd", 0, CMD_DATE_SERIAL, k[3:0], 0, 0,
                16'h00A5 ^ 16'(k));
        op("sn idx", 0, CMD_DATE_SERIAL, 4'hC, 0, 1, 0);
        $display("test serial block done");
        pin_chk("pins rst", 5'h06);
        i_power_good = 1'b1;
        i_primary_on = 1'b1;
        pin_chk("pg neg", 5'h14);
        op("pol", 1, CMD_PG_POLARITY, 0, 16'h0001, 0, 0);
        pin_chk("pg pos", 5'h16);
        op("and pos", 1, CMD_ONOFF_LOGIC, 0, 16'h0003, 0, 0);
        pin_chk("sec off", 5'h06);
        i_pin_one = 1'b1;
        pin_chk("sec on", 5'h16);
        op("and neg", 1, CMD_ONOFF_LOGIC, 0, 16'h0002, 0, 0);
        pin_chk("neg off", 5'h06);
        op("map2", 1, CMD_PIN_FUNC, 0, 16'h0002, 0, 0);
        pin_chk("map2 on", 5'h18);
        pin_two_drv = 1'b1;
        pin_chk("map2 off", 5'h08);
        op("map1", 1, CMD_PIN_FUNC, 0, 16'h0011, 0, 0);
        pin_chk("map1", 5'h0E);
        i_smbalert = 1'b1;
        pin_chk("alert", 5'h0F);
        op("ignore", 1, CMD_ONOFF_LOGIC, 0, 16'h0000, 0, 0);
        pin_chk("ignored", 5'h1F);
        op("bad map", 1, CMD_PIN_FUNC, 0, 16'h0003, 1, 0);
        op("map rd", 0, CMD_PIN_FUNC, 0, 0, 0, 16'h0011);
        $display("test pins done");
        complete_run();
    end
    // Tests need about 250 cycles; 50us is some twenty times that
    initial begin
        #50us;
        n_fail++;
        complete_run();
    end
endmodule : pmcfg_registers_tb
`default_nettype wire
